// File: design/task_file_consts.vh
`ifndef TASK_FILE_CONSTS_VH
`define TASK_FILE_CONSTS_VH

// register offsets on the host address lines
`define OFS_FAULT 4'h1
`define OFS_COUNT 4'h2
`define OFS_SECTOR 4'h3
`define OFS_ADDR_MID 4'h4
`define OFS_ADDR_UP 4'h5
`define OFS_UNIT 4'h6
`define OFS_PRIMARY 4'h7
`define OFS_FAULT_DUP 4'hD
`define OFS_SHADOW 4'hE

// fault_detail fields
`define FLT_BAD_BLOCK 7
`define FLT_UNFIXABLE 6
`define FLT_NOT_FOUND 4
`define FLT_ABORTED 2
`define FLT_GENERAL 0
`define FLT_VALID_MASK 8'hD5

// unit_and_address_mode fields
`define UNIT_LBA_BIT 6
`define UNIT_SELECT_BIT 4

// primary_condition fields
`define ST_BUSY 7
`define ST_READY 6
`define ST_WRITE_FAULT 5
`define ST_SEEK_DONE 4
`define ST_DATA_REQ 3
`define ST_FIXED 2
`define ST_INDEX 1
`define ST_ERROR 0

// reset_and_irq_control fields
`define CTRL_SOFT_RESET_BIT 2
`define CTRL_IRQ_DISABLE_BIT 1
`define CTRL_KEEP_MASK 8'h06

// reset values
`define RST_FAULT 8'h00
`define RST_BYTE 8'h00
`define RST_CTRL 8'h00

// a zero sector count asks for this many sectors
`define SECTOR_ZERO_TOTAL 9'h100

`endif

// File: design/task_file_regs.v
// Summary of operation
// - set bad block bit 7 and unfixable data bit 6 from command faults.
// - set sector-not-found bit 4; fault bits 5, 3 and 1 read zero.
// - set aborted-command bit 2 on status conditions or invalid command.
// - set general fault bit 0 on any general command error.
// - byte read/write at offset 0 on the high lane reaches fault/feature.
// - a zero sector count means 256 sectors to transfer.
// - sector count reads zero on success, remaining sectors on failure.
// - block address packs sector, mid, upper and four head bits.
// - unit bit 6 picks chs or block mode; low nibble is head.
// - unit bit 4 picks drive; compare against configured copy number.
// - primary status read clears pending interrupt; shadow read does not.
// - busy bit set while device owns registers; host writes other than control locked out.
// - ready bit clear from power-up until the card can accept commands.
// - bit 5 reports write fault, bit 4 reports card ready.
// - bit 3 set while the device wants data moved.
// - bit 2 set after a corrected error without ending the read.
// - bit 1 reads zero; bit 0 flags previous command ended in error.
// - on a failed command leave first failing sector address in registers.
// - control writes accepted while busy; bits 7..3 and 0 ignored.
// - control bit 2 holds soft reset until cleared; config untouched.
// - control bit 1 disables interrupts and feeds config status bit.
`timescale 1ns/1ps
`default_nettype none
`include "task_file_consts.vh"

module task_file_regs (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_n_i,
	// host pins, asynchronous to ref_clk_i
	input wire [3:0] addr_i,
	input wire low_byte_card_select_n_i,
	input wire high_byte_card_select_n_i,
	input wire rd_n_i,
	input wire wr_n_i,
	input wire [15:0] data_i,
	output reg [15:0] data_o,
	output reg data_lo_oe_o,
	output reg data_hi_oe_o,
	// card configuration
	input wire card_copy_i,
	// card controller state, same clock
	input wire busy_i,
	input wire ready_i,
	input wire write_fault_i,
	input wire data_request_i,
	input wire fixed_data_i,
	input wire cmd_end_i,
	input wire cmd_fail_i,
	input wire [7:0] fault_flags_i,
	input wire [7:0] remaining_i,
	input wire [27:0] fail_address_i,
	// parameters to the card controller
	output wire [7:0] feature_o,
	output wire [8:0] transfer_total_o,
	output wire [27:0] block_address_o,
	output wire lba_mode_o,
	output wire [3:0] head_o,
	output wire unit_selected_o,
	output wire soft_reset_o,
	// interrupt
	output reg irq_o,
	output wire irq_disable_o
);

	localparam SYNC_W = 24;

	// two-stage synchroniser for all host pins
	reg [SYNC_W-1:0] pin_meta_reg;
	reg [SYNC_W-1:0] pin_sync_reg;
	reg rd_n_last_reg;
	reg wr_n_last_reg;

	// task file storage
	reg [7:0] fault_reg;
	reg [7:0] fault_next;
	reg [7:0] feature_reg;
	reg [7:0] feature_next;
	reg [7:0] count_reg;
	reg [7:0] count_next;
	reg [7:0] sector_reg;
	reg [7:0] sector_next;
	reg [7:0] addr_mid_reg;
	reg [7:0] addr_mid_next;
	reg [7:0] addr_up_reg;
	reg [7:0] addr_up_next;
	reg [7:0] unit_reg;
	reg [7:0] unit_next;
	reg [7:0] ctrl_reg;
	reg [7:0] ctrl_next;
	reg error_reg;
	reg error_next;
	reg fixed_reg;
	reg fixed_next;
	reg irq_pend_reg;
	reg irq_pend_next;
	reg drq_last_reg;
	reg [7:0] fault_in;

	wire [3:0] s_addr;
	wire s_ce1_n;
	wire s_ce2_n;
	wire s_rd_n;
	wire s_wr_n;
	wire [15:0] s_data;
	wire word_acc;
	wire data_word;
	wire [3:0] lo_ofs;
	wire [3:0] hi_ofs;
	wire lo_en;
	wire hi_en;
	wire wr_take;
	wire rd_done;
	wire srst;
	wire busy_view;
	wire [8:0] lo_rd;
	wire [8:0] hi_rd;
	wire prim_read;
	wire drq_rise;
	wire [SYNC_W-1:0] pin_raw;
	wire lo_prim;
	wire hi_prim;
	wire ready_view;
	wire irq_set;
	reg [7:0] status;
	reg [3:0] w_ofs;
	reg [7:0] w_dat;
	reg w_en;
	integer ln;

	// pins are gathered so one synchroniser carries the whole access
	assign pin_raw = {data_i, wr_n_i, rd_n_i, high_byte_card_select_n_i,
		low_byte_card_select_n_i, addr_i};

	// lane order of the synchronised word mirrors pin_raw
	assign s_addr = pin_sync_reg[3:0];
	assign s_ce1_n = pin_sync_reg[4];
	assign s_ce2_n = pin_sync_reg[5];
	assign s_rd_n = pin_sync_reg[6];
	assign s_wr_n = pin_sync_reg[7];
	assign s_data = pin_sync_reg[23:8];

	// lane decode: high lane alone reaches the odd register of the pair
	assign word_acc = ~s_ce1_n & ~s_ce2_n;
	// a word access at offsets 0/1 belongs to the data port, not to us
	assign data_word = word_acc && (s_addr[3:1] == 3'h0);
	assign lo_ofs = word_acc ? {s_addr[3:1], 1'b0} : s_addr;
	assign hi_ofs = {s_addr[3:1], 1'b1};
	assign lo_en = ~s_ce1_n & ~data_word;
	assign hi_en = ~s_ce2_n & ~data_word;

	// act at the trailing edge so the synchronised data has settled
	assign wr_take = s_wr_n & ~wr_n_last_reg;
	assign rd_done = s_rd_n & ~rd_n_last_reg;

	assign srst = ctrl_reg[`CTRL_SOFT_RESET_BIT];
	assign busy_view = busy_i | srst;
	// ready is hidden while soft reset holds the card
	assign ready_view = ready_i & ~srst;

	// status is rebuilt every cycle from live controller levels and the stored corrected and error flags
	always @* begin
		status = 8'h00;
		status[`ST_BUSY] = busy_view;
		status[`ST_READY] = ready_view;
		status[`ST_WRITE_FAULT] = write_fault_i;
		status[`ST_SEEK_DONE] = ready_i;
		status[`ST_DATA_REQ] = data_request_i;
		status[`ST_FIXED] = fixed_reg;
		status[`ST_INDEX] = 1'b0;
		status[`ST_ERROR] = error_reg;
	end

	function [8:0] read_byte;
		input [3:0] ofs;
		begin
			case (ofs)
				`OFS_FAULT: read_byte = {1'b1, fault_reg & `FLT_VALID_MASK};
				`OFS_FAULT_DUP: read_byte = {1'b1, fault_reg & `FLT_VALID_MASK};
				`OFS_COUNT: read_byte = {1'b1, count_reg};
				`OFS_SECTOR: read_byte = {1'b1, sector_reg};
				`OFS_ADDR_MID: read_byte = {1'b1, addr_mid_reg};
				`OFS_ADDR_UP: read_byte = {1'b1, addr_up_reg};
				`OFS_UNIT: read_byte = {1'b1, unit_reg};
				`OFS_PRIMARY: read_byte = {1'b1, status};
				`OFS_SHADOW: read_byte = {1'b1, status};
				default: read_byte = 9'h000;
			endcase
		end
	endfunction

	// both lanes are looked up every cycle; the enables decide what is driven
	assign lo_rd = read_byte(lo_ofs);
	assign hi_rd = read_byte(hi_ofs);
	// only the primary offset clears; the shadow copy leaves it pending
	assign lo_prim = lo_en && (lo_ofs == `OFS_PRIMARY);
	assign hi_prim = hi_en && (hi_ofs == `OFS_PRIMARY);
	assign prim_read = rd_done && (lo_prim || hi_prim);

	// edge, not level: a standing request would re-arm after every status read
	assign drq_rise = data_request_i & ~drq_last_reg;
	// completion and a new data request both raise the pending flag
	assign irq_set = cmd_end_i | drq_rise;

	// fault inputs pass field by field; undefined positions never latch
	// so they cannot leak through a later read
	always @* begin
		fault_in = 8'h00;
		fault_in[`FLT_BAD_BLOCK] = fault_flags_i[`FLT_BAD_BLOCK];
		fault_in[`FLT_UNFIXABLE] = fault_flags_i[`FLT_UNFIXABLE];
		fault_in[`FLT_NOT_FOUND] = fault_flags_i[`FLT_NOT_FOUND];
		fault_in[`FLT_ABORTED] = fault_flags_i[`FLT_ABORTED];
		fault_in[`FLT_GENERAL] = fault_flags_i[`FLT_GENERAL];
	end

	always @* begin
		fault_next = fault_reg;
		feature_next = feature_reg;
		count_next = count_reg;
		sector_next = sector_reg;
		addr_mid_next = addr_mid_reg;
		addr_up_next = addr_up_reg;
		unit_next = unit_reg;
		ctrl_next = ctrl_reg;
		error_next = error_reg;
		fixed_next = fixed_reg;
		irq_pend_next = irq_pend_reg;
		w_ofs = 4'h0;
		w_dat = 8'h00;
		w_en = 1'b0;
		// a word access writes both lanes on the same strobe
		for (ln = 0; ln < 2; ln = ln + 1) begin
			w_ofs = (ln == 1) ? hi_ofs : lo_ofs;
			w_dat = (ln == 1) ? s_data[15:8] : s_data[7:0];
			w_en = wr_take & ((ln == 1) ? hi_en : lo_en);
			if (w_en && w_ofs == `OFS_SHADOW) begin
				// control stays writable while busy, unused bits dropped
				ctrl_next = w_dat & `CTRL_KEEP_MASK;
			end else if (w_en && !busy_view) begin
				case (w_ofs)
					`OFS_FAULT: feature_next = w_dat;
					`OFS_FAULT_DUP: feature_next = w_dat;
					`OFS_COUNT: count_next = w_dat;
					`OFS_SECTOR: sector_next = w_dat;
					`OFS_ADDR_MID: addr_mid_next = w_dat;
					`OFS_ADDR_UP: addr_up_next = w_dat;
					// bits 7 and 5 are stored but steer nothing
					`OFS_UNIT: unit_next = w_dat;
					default: begin
					end
				endcase
			end
		end
		// primary status read clears the corrected flag; a new event wins
		if (prim_read) begin
			fixed_next = 1'b0;
		end
		if (fixed_data_i) begin
			fixed_next = 1'b1;
		end
		if (cmd_end_i) begin
			error_next = cmd_fail_i;
			// only the documented fault bits can be set
			fault_next = cmd_fail_i ? fault_in : `RST_FAULT;
			count_next = cmd_fail_i ? remaining_i : 8'h00;
			// a failed command leaves the first bad sector in the address registers
			if (cmd_fail_i) begin
				sector_next = fail_address_i[7:0];
				addr_mid_next = fail_address_i[15:8];
				addr_up_next = fail_address_i[23:16];
				unit_next = {unit_reg[7:4], fail_address_i[27:24]};
			end
		end
		// set wins over the read clear so no completion is lost
		if (prim_read) begin
			irq_pend_next = 1'b0;
		end
		if (irq_set) begin
			irq_pend_next = 1'b1;
		end
		// soft reset holds the task file; control register survives
		if (srst) begin
			fault_next = `RST_FAULT;
			feature_next = `RST_BYTE;
			count_next = `RST_BYTE;
			sector_next = `RST_BYTE;
			addr_mid_next = `RST_BYTE;
			addr_up_next = `RST_BYTE;
			unit_next = `RST_BYTE;
			error_next = 1'b0;
			fixed_next = 1'b0;
			irq_pend_next = 1'b0;
		end
	end

	// hosts must hold address, selects and data one clock past the strobe's
	// rising edge; a shorter hold is simply missed, there is no error flag
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_meta_reg <= {SYNC_W{1'b1}};
			pin_sync_reg <= {SYNC_W{1'b1}};
			rd_n_last_reg <= 1'b1;
			wr_n_last_reg <= 1'b1;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			rd_n_last_reg <= s_rd_n;
			wr_n_last_reg <= s_wr_n;
		end
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_reg <= `RST_FAULT;
			feature_reg <= `RST_BYTE;
			count_reg <= `RST_BYTE;
			sector_reg <= `RST_BYTE;
			addr_mid_reg <= `RST_BYTE;
			addr_up_reg <= `RST_BYTE;
			unit_reg <= `RST_BYTE;
			ctrl_reg <= `RST_CTRL;
			error_reg <= 1'b0;
			fixed_reg <= 1'b0;
			irq_pend_reg <= 1'b0;
			drq_last_reg <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			fault_reg <= fault_next;
			feature_reg <= feature_next;
			count_reg <= count_next;
			sector_reg <= sector_next;
			addr_mid_reg <= addr_mid_next;
			addr_up_reg <= addr_up_next;
			unit_reg <= unit_next;
			// control survives a soft reset, so only the host can end it
			ctrl_reg <= ctrl_next;
			error_reg <= error_next;
			fixed_reg <= fixed_next;
			irq_pend_reg <= irq_pend_next;
			drq_last_reg <= data_request_i;
			// disable gates the pin only; the pending flag is kept
			irq_o <= irq_pend_next & ~ctrl_next[`CTRL_IRQ_DISABLE_BIT];
		end
	end

	// read data is refreshed every cycle; only the output enables wait for the strobe to be low
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_o <= 16'h0000;
			data_lo_oe_o <= 1'b0;
			data_hi_oe_o <= 1'b0;
		end else begin
			data_lo_oe_o <= ~s_rd_n & lo_en & lo_rd[8];
			data_hi_oe_o <= ~s_rd_n & hi_en & hi_rd[8];
			data_o <= {hi_rd[7:0], lo_rd[7:0]};
		end
	end

	assign feature_o = feature_reg;
	// nine bits so a zero count reaches the controller already expanded
	assign transfer_total_o = (count_reg == 8'h00) ? `SECTOR_ZERO_TOTAL
		: {1'b0, count_reg};
	// chs mode keeps the same packing: head nibble, cylinder, sector
	assign block_address_o = {unit_reg[3:0], addr_up_reg, addr_mid_reg, sector_reg};
	assign lba_mode_o = unit_reg[`UNIT_LBA_BIT];
	assign head_o = unit_reg[3:0];
	// the block answers whichever unit is picked; the controller gates on this
	assign unit_selected_o = (unit_reg[`UNIT_SELECT_BIT] == card_copy_i);
	assign soft_reset_o = srst;
	assign irq_disable_o = ctrl_reg[`CTRL_IRQ_DISABLE_BIT];

endmodule // task_file_regs
`default_nettype wire

// File: verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock and device answer
	input wire logic ref_clk_i,
	input wire logic [15:0] data_o,
	input wire logic data_lo_oe_o,
	input wire logic data_hi_oe_o,
	// host pins
	output logic [3:0] addr_o,
	output logic lo_n_o,
	output logic hi_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [15:0] wdata_o
);
	initial begin
		addr_o = 4'h0;
		lo_n_o = 1'b1;
		hi_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		wdata_o = 16'h0000;
	end

	// pins stay put four clocks past the strobe: the device samples through two flops
	// ln: 00 low lane alone, 01 high lane alone, 1x both lanes as one word
	task automatic bus(input logic w, input logic [3:0] a, input logic [1:0] ln,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		@(negedge ref_clk_i);
		addr_o = a;
		lo_n_o = ln[0] & ~ln[1];
		hi_n_o = ~ln[0] & ~ln[1];
		wdata_o = {d, d};
		rd_n_o = w;
		wr_n_o = !w;
		ok = w;
		q = 8'h00;
		for (int n = 0; n < 10 && !ok; n++) begin
			// look between edges, where enable and data have settled together
			@(negedge ref_clk_i);
			ok = ln[0] ? data_hi_oe_o : data_lo_oe_o;
			q = ln[0] ? data_o[15:8] : data_o[7:0];
		end
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		lo_n_o = 1'b1;
		hi_n_o = 1'b1;
		// released lines flip so stale data never looks valid
		wdata_o = ~wdata_o;
	endtask
endmodule // host_model
`default_nettype wire

// File: verification/task_file_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module task_file_monitor (
	// watched ports
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic rd_n_i,
	input wire logic data_lo_oe_o,
	input wire logic data_hi_oe_o,
	input wire logic cmd_end_i,
	input wire logic cmd_fail_i,
	input wire logic [7:0] remaining_i,
	input wire logic [27:0] fail_address_i,
	input wire logic [8:0] transfer_total_o,
	input wire logic [27:0] block_address_o,
	input wire logic [3:0] head_o,
	input wire logic soft_reset_o,
	input wire logic irq_o,
	input wire logic irq_disable_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	total_zero_a: assert property (transfer_total_o[8] == (transfer_total_o[7:0] == 8'h00))
		else $error("sector total decode");
	block_addr_a: assert property (block_address_o[27:24] == head_o)
		else $error("block address top nibble");
	success_clear_a: assert property (cmd_end_i && !cmd_fail_i |=> transfer_total_o == 9'h100)
		else $error("count not zero after success");
	fail_load_a: assert property (cmd_end_i && cmd_fail_i && !soft_reset_o |=>
		transfer_total_o[7:0] == $past(remaining_i) && block_address_o == $past(fail_address_i))
		else $error("failure state not loaded");
	end_irq_a: assert property (cmd_end_i && !irq_disable_o && !soft_reset_o |=> irq_o)
		else $error("no interrupt at command end");
	irq_gate_a: assert property (irq_disable_o && $past(irq_disable_o) |-> !irq_o)
		else $error("interrupt while disabled");
	soft_hold_a: assert property (soft_reset_o && $past(soft_reset_o) |->
		transfer_total_o == 9'h100 && block_address_o == 28'h0000000)
		else $error("task file not held in soft reset");
	oe_read_a: assert property (data_lo_oe_o || data_hi_oe_o |->
		!$past(rd_n_i, 3) || !$past(rd_n_i, 4))
		else $error("data driven without read");
	cover property (cmd_end_i && cmd_fail_i);
	cover property ($rose(soft_reset_o));
	cover property ($fell(irq_o));
endmodule // task_file_monitor
bind task_file_regs task_file_monitor mon (.*);
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr_i, head_o;
	logic low_byte_card_select_n_i, high_byte_card_select_n_i, rd_n_i, wr_n_i, ok;
	logic [15:0] data_i, data_o;
	logic data_lo_oe_o, data_hi_oe_o, card_copy_i = 1'b0, busy_i = 1'b0, ready_i = 1'b0;
	logic write_fault_i = 1'b0, data_request_i = 1'b0, fixed_data_i = 1'b0;
	logic cmd_end_i = 1'b0, cmd_fail_i = 1'b0;
	logic [7:0] fault_flags_i = 8'h00, remaining_i = 8'h00, feature_o, rq;
	logic [27:0] fail_address_i = 28'h0000000, block_address_o;
	logic [8:0] transfer_total_o;
	logic lba_mode_o, unit_selected_o, soft_reset_o, irq_o, irq_disable_o;
	int num_errors = 0;
	int tests_run = 0;
	logic [3:0] ra [7] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0};
	logic [6:0] rh = 7'h40;
	logic [7:0] rw [7] = '{8'h00, 8'h55, 8'hA5, 8'h3C, 8'hC3, 8'hE7, 8'h9A};
	logic [7:0] rr [7] = '{8'h00, 8'h55, 8'hA5, 8'h3C, 8'hC3, 8'hE7, 8'h00};

	always #5 ref_clk_i = ~ref_clk_i;

	task_file_regs uut (.*);
	host_model host (.ref_clk_i(ref_clk_i), .data_o(data_o), .data_lo_oe_o(data_lo_oe_o),
		.data_hi_oe_o(data_hi_oe_o), .addr_o(addr_i), .lo_n_o(low_byte_card_select_n_i),
		.hi_n_o(high_byte_card_select_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .wdata_o(data_i));

	task automatic check(input string nm, input logic [27:0] got, input logic [27:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [3:0] a, input logic hi, input logic [7:0] d);
		host.bus(w, a, {1'b0, hi}, d, rq, ok);
		// an unanswered read counts against the run, which still reaches the verdict
		if (ok !== 1'b1) begin
			num_errors++;
		end
	endtask

	task automatic wacc(input logic [3:0] a, input logic [7:0] d);
		host.bus(1'b1, a, 2'b10, d, rq, ok);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		acc(1'b0, a, 1'b0, 8'h00);
		check("read data", rq, e);
	endtask

	task automatic pulse(input logic e, input logic f, input logic x);
		@(negedge ref_clk_i);
		cmd_end_i = e;
		cmd_fail_i = f;
		fixed_data_i = x;
		@(negedge ref_clk_i);
		cmd_end_i = 1'b0;
		fixed_data_i = 1'b0;
	endtask

	initial begin
		repeat (20) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		check("total", transfer_total_o, 9'h100);
		check("control", {irq_o, irq_disable_o, soft_reset_o}, 3'b000);
		rd(4'h7, 8'h00);
		ready_i = 1'b1;
		for (int i = 0; i < 7; i++) begin
			acc(1'b1, ra[i], rh[i], rw[i]);
			acc(1'b0, ra[i], rh[i], 8'h00);
			check("readback", rq, rr[i]);
		end
		check("total", transfer_total_o, 9'h055);
		check("address", block_address_o, 28'h7C33CA5);
		check("feature", feature_o, 8'h9A);
		wacc(4'h4, 8'h5A);
		check("word pair", block_address_o, 28'h75A5AA5);
		wacc(4'h0, 8'h11);
		check("word data port", feature_o, 8'h9A);
		acc(1'b1, 4'h6, 1'b0, 8'hB5);
		card_copy_i = 1'b1;
		#1 check("unit", {unit_selected_o, lba_mode_o, head_o}, 6'h25);
		@(negedge ref_clk_i);
		card_copy_i = 1'b0;
		#1 check("unit", unit_selected_o, 1'b0);
		busy_i = 1'b1;
		acc(1'b1, 4'h2, 1'b0, 8'h11);
		check("locked", transfer_total_o, 9'h055);
		fault_flags_i = 8'hFF;
		remaining_i = 8'h07;
		fail_address_i = 28'h1234567;
		pulse(1'b1, 1'b1, 1'b0);
		busy_i = 1'b0;
		check("remaining", transfer_total_o, 9'h007);
		check("fail address", block_address_o, 28'h1234567);
		check("irq", irq_o, 1'b1);
		rd(4'h1, 8'hD5);
		rd(4'hD, 8'hD5);
		rd(4'hE, 8'h51);
		check("irq kept", irq_o, 1'b1);
		rd(4'h7, 8'h51);
		check("irq cleared", irq_o, 1'b0);
		acc(1'b1, 4'hE, 1'b0, 8'hFA);
		check("control", {soft_reset_o, irq_disable_o}, 2'b01);
		data_request_i = 1'b1;
		write_fault_i = 1'b1;
		pulse(1'b1, 1'b0, 1'b1);
		check("total", transfer_total_o, 9'h100);
		check("irq masked", irq_o, 1'b0);
		rd(4'hE, 8'h7C);
		acc(1'b1, 4'hE, 1'b0, 8'h00);
		check("irq", irq_o, 1'b1);
		busy_i = 1'b1;
		acc(1'b1, 4'hE, 1'b0, 8'h04);
		busy_i = 1'b0;
		check("soft reset", {soft_reset_o, irq_o, transfer_total_o}, 11'h500);
		acc(1'b0, 4'hE, 1'b0, 8'h00);
		check("soft busy", rq[7:6], 2'b10);
		acc(1'b1, 4'hE, 1'b0, 8'h00);
		check("soft reset", soft_reset_o, 1'b0);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
